//--- hdl/fis_sched_pkg.sv
// Purpose: shared constants for the switching-mode port scheduler
// Assumes: 32 command slots, 16 devices behind an optional port multiplier
// Notes:   offsets are byte addresses on the plain register port
package fis_sched_pkg;

	localparam int          NUM_SLOTS    = 32;
	localparam int          NUM_DEVS     = 16;
	localparam int          SLOT_W       = 5;
	localparam int          DEV_W        = 4;
	localparam int          AGE_W        = 6;
	localparam int          ADDR_W       = 8;
	localparam logic [3:0]  CTRL_PORT    = 4'hf;
	localparam logic [3:0]  LINK_UP      = 4'h3;
	localparam logic [3:0]  DET_NONE     = 4'h0;
	localparam logic [3:0]  ICC_NONE     = 4'h0;
	localparam logic [63:0] HDR_BYTES    = 64'h20;

	// register offsets
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_ISSUE    = 8'h08;
	localparam logic [7:0]  OFS_QACT     = 8'h0c;
	localparam logic [7:0]  OFS_SLOT_DEV = 8'h10;
	localparam logic [7:0]  OFS_FBS      = 8'h14;
	localparam logic [7:0]  OFS_CLB_LO   = 8'h18;
	localparam logic [7:0]  OFS_CLB_HI   = 8'h1c;

	// control register fields
	localparam int          CTRL_SPIN_UP = 0;
	localparam int          CTRL_PWR_ON  = 1;
	localparam int          CTRL_PWR_OFF = 2;
	localparam int          CTRL_RUN     = 3;
	localparam int          CTRL_DET_LSB = 4;
	localparam int          CTRL_ICC_LSB = 28;
	// slot-to-device write fields
	localparam int          SD_SLOT_LSB  = 0;
	localparam int          SD_DEV_LSB   = 8;
	// switching status/control fields
	localparam int          FBS_DEC      = 0;
	localparam int          FBS_SDE      = 1;
	localparam int          FBS_DWE_LSB  = 8;
	// header dword 0: target port field
	localparam int          HDR_PMP_LSB  = 12;

	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic        PWR_RESET    = 1'b0;

endpackage : fis_sched_pkg

//--- hdl/dev_picker.sv
// Purpose: choose the next device to serve among the eligible ones
// Assumes: eligibility already includes busy, data-request and transfer gating
// Notes:   control port wins, others rotate after the last one served
`timescale 1ns/10ps
module dev_picker
	import fis_sched_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire logic [NUM_DEVS-1:0] eligible,
	input  wire logic                take,
	output logic                     any_valid,
	output logic [DEV_W-1:0]         pick
);

	logic [DEV_W-1:0] last_q;
	logic [DEV_W-1:0] idx;
	logic             found;

	// round robin search from the device after the last one served
	always_comb begin
		found = 1'b0;
		pick  = '0;
		idx   = '0;
		if (eligible[CTRL_PORT]) begin
			found = 1'b1;
			pick  = CTRL_PORT;
		end else begin
			for (int i = 1; i <= NUM_DEVS; i++) begin
				idx = last_q + DEV_W'(i);
				if (!found && eligible[idx]) begin
					found = 1'b1;
					pick  = idx;
				end
			end
		end
		any_valid = found;
	end

	// remember whom we served so nobody starves
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			last_q <= '0;
		end else if (take && found) begin
			last_q <= pick;
		end
	end

endmodule : dev_picker

//--- hdl/cmd_picker.sv
// Purpose: track how long each issued slot has waited and pick the oldest
// Assumes: one issue write sets its whole group of slots at once
// Notes:   ages saturate, so very old slots tie and the lowest index of them goes
`timescale 1ns/10ps
module cmd_picker
	import fis_sched_pkg::*;
(
	input  wire logic                      core_clk,
	input  wire logic                      rst_b,
	input  wire logic [NUM_SLOTS-1:0]      pending,
	input  wire logic [NUM_SLOTS-1:0]      issue_set,
	input  wire logic [NUM_SLOTS*DEV_W-1:0] slot_dev,
	input  wire logic [DEV_W-1:0]          dev,
	output logic [SLOT_W-1:0]              oldest
);

	logic [AGE_W-1:0] age_q [NUM_SLOTS];
	logic [AGE_W-1:0] best;
	logic             seen;

	// new writes age every slot still waiting
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int s = 0; s < NUM_SLOTS; s++) age_q[s] <= '0;
		end else if (|issue_set) begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				if (issue_set[s])
					age_q[s] <= '0;
				else if (pending[s] && age_q[s] != {AGE_W{1'b1}})
					age_q[s] <= age_q[s] + AGE_W'(1);
			end
		end
	end

	// oldest waiting slot of the chosen device, lowest index on a tie
	always_comb begin
		best   = '0;
		seen   = 1'b0;
		oldest = '0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (pending[s] && slot_dev[s*DEV_W +: DEV_W] == dev
			    && (!seen || age_q[s] > best)) begin
				seen   = 1'b1;
				best   = age_q[s];
				oldest = SLOT_W'(s);
			end
		end
	end

endmodule : cmd_picker

//--- hdl/fis_switch_port_scheduler.sv
// Purpose: per-port scheduler for switching mode, power and listen states
// Assumes: all inputs come from logic on core_clk; memory answers reads later
// Notes:   outside handlers take over in the hand-off states, then return
//
// Function
// - power-off state drives the power switch off, then goes to not-running
// - listen state puts the physical layer in listen mode, then not-running
// - spin-up falling while detect control is zero enters the listen state
// - entering switching idle sets the command-list-running status bit
// - idle exits: link down, device select, data frame, non-data frame
// - transmit only with a command waiting and selected device count zero
// - then low power, interface-control write, device sleep, else stay idle
// - issue only when transfer count, busy and data-request are all zero
// - select an unblocked device with pending slot, without starving any
// - prefer the control port, then go on to command selection
// - pick the oldest unissued slot of the device, record it, fetch
// - among slots set by one issue write any oldest one may go
// - fetch header, store issue slot, set command-waiting, back to idle
// - busy must be set for the chosen command before it is issued
// - on device error write failing device first, then set error flag
// - cleanup flushes failed device slots and clears its busy, request
// - then clear error flag, clear error-clear bit, return to idle
// - power-on state drives the power switch on, then goes to not-running
`timescale 1ns/10ps
module fis_switch_port_scheduler
	import fis_sched_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [31:0]              reg_rdata,
	input  wire logic [3:0]          link_detect_status,
	input  wire logic                data_fis_rx,
	input  wire logic                nondata_fis_rx,
	input  wire logic                link_low_power,
	input  wire logic                idle_timeout_flag,
	input  wire logic                sleep_exit_only_cap,
	input  wire logic [NUM_DEVS-1:0] dma_xfer_zero,
	input  wire logic                handler_done,
	input  wire logic                cmd_sent,
	input  wire logic                cmd_done,
	input  wire logic [SLOT_W-1:0]   cmd_done_slot,
	input  wire logic                dev_status_upd,
	input  wire logic [DEV_W-1:0]    dev_status_dev,
	input  wire logic                dev_status_bsy,
	input  wire logic                dev_status_drq,
	input  wire logic                dev_error,
	input  wire logic [DEV_W-1:0]    dev_error_dev,
	output logic                     mem_rd_req,
	output logic [63:0]              mem_rd_addr,
	input  wire logic                mem_rd_ack,
	input  wire logic [31:0]         mem_rd_data,
	output logic [31:0]              cmd_header,
	output logic [DEV_W-1:0]         xmit_dev,
	output logic [SLOT_W-1:0]        xmit_slot,
	output logic [2:0]               handoff,
	output logic                     handoff_go,
	output logic                     dev_power_en,
	output logic                     phy_listen
);

	typedef enum logic [3:0] {
		not_running_state, power_on_state, power_off_state, phy_listen_state,
		switch_idle_state, device_select_state, cmd_select_state, cmd_fetch_state,
		cmd_transmit_state, data_receive_entry, nondata_receive_entry,
		low_power_state, iface_ctl_state, device_sleep_state,
		device_error_state, device_error_cleanup_state
	} sched_state_e;

	sched_state_e          state_q, state_d;
	logic [31:0]           ctrl_q;
	logic [NUM_SLOTS-1:0]  cmd_issue_reg_q;
	logic [NUM_SLOTS-1:0]  queue_active_reg_q;
	logic [NUM_SLOTS-1:0]  pending_q;
	logic [NUM_SLOTS*DEV_W-1:0] slot_dev_q;
	logic [63:0]           cmd_list_base_q;
	logic [NUM_DEVS-1:0]   busy_flag_q, data_request_flag_q;
	logic [SLOT_W-1:0]     issue_slot_per_device_q [NUM_DEVS];
	logic [DEV_W-1:0]      selected_device_q;
	logic [SLOT_W-1:0]     selected_slot_q;
	logic                  cmd_awaiting_issue_q;
	logic                  cmd_list_running_q;
	logic [DEV_W-1:0]      error_device_field_q;
	logic                  single_device_error_flag_q;
	logic                  device_error_clear_q;
	logic                  iface_write_q;
	logic                  pwr_on_req_q, pwr_off_req_q, listen_req_q;
	logic                  fetch_wait_q;
	logic [NUM_DEVS-1:0]   dev_pending, eligible;
	logic [NUM_SLOTS-1:0]  issue_set, dev_slots;
	logic                  dev_valid;
	logic [DEV_W-1:0]      dev_pick;
	logic [SLOT_W-1:0]     slot_pick;
	logic                  wr_ctrl, wr_fbs;

	function automatic logic [DEV_W-1:0] slot_owner(input logic [NUM_SLOTS*DEV_W-1:0] map,
	                                                 input int s);
		return map[s*DEV_W +: DEV_W];
	endfunction : slot_owner

	assign wr_ctrl   = reg_wr && reg_addr == OFS_CTRL;
	assign wr_fbs    = reg_wr && reg_addr == OFS_FBS;
	assign issue_set = (reg_wr && reg_addr == OFS_ISSUE) ? reg_wdata & ~cmd_issue_reg_q : '0;

	// per-device pending work and issue eligibility
	always_comb begin
		dev_pending = '0;
		dev_slots   = '0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (pending_q[s])
				dev_pending[slot_owner(slot_dev_q, s)] = 1'b1;
			dev_slots[s] = slot_owner(slot_dev_q, s) == error_device_field_q;
		end
		eligible = dev_pending & ~busy_flag_q & ~data_request_flag_q & dma_xfer_zero;
	end

	dev_picker u_dev_picker (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.eligible  (eligible),
		.take      (state_q == device_select_state),
		.any_valid (dev_valid),
		.pick      (dev_pick)
	);

	cmd_picker u_cmd_picker (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.pending   (pending_q),
		.issue_set (issue_set),
		.slot_dev  (slot_dev_q),
		.dev       (selected_device_q),
		.oldest    (slot_pick)
	);

	// next state
	always_comb begin
		state_d = state_q;
		if (pwr_off_req_q) begin
			state_d = power_off_state;
		end else if (pwr_on_req_q) begin
			state_d = power_on_state;
		end else if (listen_req_q) begin
			state_d = phy_listen_state;
		end else if (dev_error && state_q != device_error_state
		             && state_q != device_error_cleanup_state && state_q != not_running_state) begin
			state_d = device_error_state;
		end else begin
			case (state_q)
				not_running_state: begin
					if (ctrl_q[CTRL_RUN] && link_detect_status == LINK_UP)
						state_d = switch_idle_state;
				end
				power_on_state:  state_d = not_running_state;
				power_off_state: state_d = not_running_state;
				phy_listen_state: state_d = not_running_state;
				switch_idle_state: begin
					if (link_detect_status != LINK_UP)
						state_d = not_running_state;
					else if (!cmd_awaiting_issue_q && dev_valid)
						state_d = device_select_state;
					else if (data_fis_rx)
						state_d = data_receive_entry;
					else if (nondata_fis_rx)
						state_d = nondata_receive_entry;
					else if (cmd_awaiting_issue_q && dma_xfer_zero[selected_device_q])
						state_d = cmd_transmit_state;
					else if (link_low_power)
						state_d = low_power_state;
					else if (iface_write_q)
						state_d = iface_ctl_state;
					else if (idle_timeout_flag && !sleep_exit_only_cap)
						state_d = device_sleep_state;
				end
				device_select_state: state_d = cmd_select_state;
				cmd_select_state:    state_d = cmd_fetch_state;
				cmd_fetch_state: begin
					if (fetch_wait_q && mem_rd_ack)
						state_d = switch_idle_state;
				end
				cmd_transmit_state, data_receive_entry, nondata_receive_entry,
				low_power_state, iface_ctl_state, device_sleep_state: begin
					if (handler_done)
						state_d = switch_idle_state;
				end
				device_error_state: begin
					if (device_error_clear_q)
						state_d = device_error_cleanup_state;
				end
				device_error_cleanup_state: state_d = switch_idle_state;
				default: state_d = not_running_state;
			endcase
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			state_q <= not_running_state;
		else
			state_q <= state_d;
	end

	// control register and one-shot power and listen requests
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q        <= CTRL_RESET;
			pwr_on_req_q  <= 1'b0;
			pwr_off_req_q <= 1'b0;
			listen_req_q  <= 1'b0;
			iface_write_q <= 1'b0;
		end else begin
			// a request drops as its state is entered, so each state lasts one cycle
			pwr_on_req_q  <= (wr_ctrl && reg_wdata[CTRL_PWR_ON])
			                 || (pwr_on_req_q && state_d != power_on_state);
			pwr_off_req_q <= (wr_ctrl && reg_wdata[CTRL_PWR_OFF])
			                 || (pwr_off_req_q && state_d != power_off_state);
			listen_req_q  <= (wr_ctrl && ctrl_q[CTRL_SPIN_UP] && !reg_wdata[CTRL_SPIN_UP]
			                  && reg_wdata[CTRL_DET_LSB +: 4] == DET_NONE)
			                 || (listen_req_q && state_d != phy_listen_state);
			if (wr_ctrl && reg_wdata[CTRL_ICC_LSB +: 4] != ICC_NONE)
				iface_write_q <= 1'b1;
			else if (state_q == iface_ctl_state)
				iface_write_q <= 1'b0;
			if (wr_ctrl)
				ctrl_q <= reg_wdata;
		end
	end

	// device power switch and listen mode outputs
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dev_power_en <= PWR_RESET;
			phy_listen   <= 1'b0;
		end else begin
			if (state_q == power_off_state)
				dev_power_en <= 1'b0;
			else if (state_q == power_on_state)
				dev_power_en <= 1'b1;
			if (state_q == phy_listen_state)
				phy_listen <= 1'b1;
			else if (state_q == power_on_state || state_d == switch_idle_state)
				phy_listen <= 1'b0;
		end
	end

	// running status
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			cmd_list_running_q <= 1'b0;
		else if (state_d == switch_idle_state)
			cmd_list_running_q <= 1'b1;
		else if (state_d == not_running_state)
			cmd_list_running_q <= 1'b0;
	end

	// issue, queue-active and waiting-to-issue slot sets
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_issue_reg_q    <= '0;
			queue_active_reg_q <= '0;
			pending_q          <= '0;
		end else begin
			for (int s = 0; s < NUM_SLOTS; s++) begin
				if (issue_set[s]) begin
					cmd_issue_reg_q[s] <= 1'b1;
					pending_q[s]       <= 1'b1;
				end else if (state_q == device_error_cleanup_state && dev_slots[s]) begin
					cmd_issue_reg_q[s] <= 1'b0;
					pending_q[s]       <= 1'b0;
				end else begin
					if (cmd_done && cmd_done_slot == SLOT_W'(s))
						cmd_issue_reg_q[s] <= 1'b0;
					if (state_q == cmd_select_state && slot_pick == SLOT_W'(s))
						pending_q[s] <= 1'b0;
				end
				if (reg_wr && reg_addr == OFS_QACT && reg_wdata[s])
					queue_active_reg_q[s] <= 1'b1;
				else if (state_q == device_error_cleanup_state && dev_slots[s])
					queue_active_reg_q[s] <= 1'b0;
			end
		end
	end

	// slot owner map and command list base
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_dev_q      <= '0;
			cmd_list_base_q <= '0;
		end else begin
			if (reg_wr && reg_addr == OFS_SLOT_DEV)
				slot_dev_q[reg_wdata[SD_SLOT_LSB +: SLOT_W]*DEV_W +: DEV_W]
				    <= reg_wdata[SD_DEV_LSB +: DEV_W];
			if (reg_wr && reg_addr == OFS_CLB_LO)
				cmd_list_base_q[31:0] <= reg_wdata;
			if (reg_wr && reg_addr == OFS_CLB_HI)
				cmd_list_base_q[63:32] <= reg_wdata;
		end
	end

	// per-device busy and data-request flags
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_flag_q         <= '0;
			data_request_flag_q <= '0;
		end else begin
			for (int d = 0; d < NUM_DEVS; d++) begin
				if (state_q == cmd_select_state && selected_device_q == DEV_W'(d))
					busy_flag_q[d] <= 1'b1;
				else if (dev_status_upd && dev_status_dev == DEV_W'(d))
					busy_flag_q[d] <= dev_status_bsy;
				else if (state_q == device_error_cleanup_state
				         && error_device_field_q == DEV_W'(d))
					busy_flag_q[d] <= 1'b0;
				if (dev_status_upd && dev_status_dev == DEV_W'(d))
					data_request_flag_q[d] <= dev_status_drq;
				else if (state_q == device_error_cleanup_state
				         && error_device_field_q == DEV_W'(d))
					data_request_flag_q[d] <= 1'b0;
			end
		end
	end

	// selection, header fetch and issue bookkeeping
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			selected_device_q    <= '0;
			selected_slot_q      <= '0;
			cmd_awaiting_issue_q <= 1'b0;
			fetch_wait_q         <= 1'b0;
			mem_rd_req           <= 1'b0;
			mem_rd_addr          <= '0;
			cmd_header           <= '0;
			xmit_dev             <= '0;
			xmit_slot            <= '0;
			for (int d = 0; d < NUM_DEVS; d++) issue_slot_per_device_q[d] <= '0;
		end else begin
			if (state_q == device_select_state)
				selected_device_q <= dev_pick;
			if (state_q == cmd_select_state) begin
				selected_slot_q <= slot_pick;
				mem_rd_req      <= 1'b1;
				fetch_wait_q    <= 1'b1;
				mem_rd_addr     <= cmd_list_base_q + 64'(slot_pick) * HDR_BYTES;
			end else if (fetch_wait_q && mem_rd_ack) begin
				mem_rd_req   <= 1'b0;
				fetch_wait_q <= 1'b0;
				cmd_header   <= mem_rd_data;
				issue_slot_per_device_q[selected_device_q] <= selected_slot_q;
				xmit_dev     <= selected_device_q;
				xmit_slot    <= selected_slot_q;
			end
			if (state_q == cmd_fetch_state && fetch_wait_q && mem_rd_ack)
				cmd_awaiting_issue_q <= 1'b1;
			else if (cmd_sent || state_d == not_running_state
			         || (state_q == device_error_cleanup_state
			             && xmit_dev == error_device_field_q))
				cmd_awaiting_issue_q <= 1'b0;
		end
	end

	// hand-off pulse toward the outside handlers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			handoff    <= '0;
			handoff_go <= 1'b0;
		end else begin
			handoff_go <= state_q == switch_idle_state && state_d != switch_idle_state
			              && state_d > device_select_state && state_d < device_error_state
			              && state_d != cmd_select_state && state_d != cmd_fetch_state;
			case (state_d)
				cmd_transmit_state:    handoff <= 3'h1;
				data_receive_entry:    handoff <= 3'h2;
				nondata_receive_entry: handoff <= 3'h3;
				low_power_state:       handoff <= 3'h4;
				iface_ctl_state:       handoff <= 3'h5;
				device_sleep_state:    handoff <= 3'h6;
				default:               handoff <= handoff;
			endcase
		end
	end

	// single-device error recording and software acknowledge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			error_device_field_q       <= '0;
			single_device_error_flag_q <= 1'b0;
			device_error_clear_q       <= 1'b0;
		end else begin
			if (state_d == device_error_state && state_q != device_error_state)
				error_device_field_q <= dev_error_dev;
			if (state_q == device_error_state)
				single_device_error_flag_q <= 1'b1;
			else if (state_q == device_error_cleanup_state)
				single_device_error_flag_q <= 1'b0;
			if (wr_fbs && reg_wdata[FBS_DEC])
				device_error_clear_q <= 1'b1;
			else if (state_q == device_error_cleanup_state)
				device_error_clear_q <= 1'b0;
		end
	end

	// read data, one cycle after the read strobe
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				case (reg_addr)
					OFS_CTRL:   reg_rdata <= ctrl_q;
					OFS_STATUS: reg_rdata <= {18'h0, issue_slot_per_device_q[selected_device_q],
					                          cmd_awaiting_issue_q, 4'(state_q),
					                          3'h0, cmd_list_running_q};
					OFS_ISSUE:  reg_rdata <= cmd_issue_reg_q;
					OFS_QACT:   reg_rdata <= queue_active_reg_q;
					OFS_FBS:    reg_rdata <= {20'h0, error_device_field_q, 6'h0,
					                          single_device_error_flag_q, device_error_clear_q};
					OFS_CLB_LO: reg_rdata <= cmd_list_base_q[31:0];
					OFS_CLB_HI: reg_rdata <= cmd_list_base_q[63:32];
					default:    reg_rdata <= '0;
				endcase
			end
		end
	end

endmodule : fis_switch_port_scheduler

//--- test/fis_sched_monitor.sv
// Purpose: port checks of the scheduler
// Assumes: bound to the top, one clock
// Notes:   windows follow the hand-over timing
`timescale 1ns/10ps
module fis_sched_monitor
	import fis_sched_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic [3:0]  link_detect_status,
	input wire logic [15:0] dma_xfer_zero,
	input wire logic        dev_error,
	input wire logic        mem_rd_req,
	input wire logic        mem_rd_ack,
	input wire logic [31:0] mem_rd_data,
	input wire logic [31:0] cmd_header,
	input wire logic [3:0]  xmit_dev,
	input wire logic [2:0]  handoff,
	input wire logic        handoff_go,
	input wire logic        dev_power_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic cw;
	// control register write
	assign cw = reg_wr && reg_addr == OFS_CTRL;
	pwr_off_a: assert property (cw && reg_wdata[2:1] == 2'b10 |-> ##[1:3] !dev_power_en)
		else $error("power left on");
	pwr_on_a: assert property (cw && reg_wdata[2:1] == 2'b01 |-> ##[1:3] dev_power_en)
		else $error("power left off");
	pwr_hold_a: assert property (!cw [*3] |=> $stable(dev_power_en))
		else $error("power moved");
	link_down_a: assert property ((link_detect_status != LINK_UP) [*3] |=> !handoff_go)
		else $error("handoff on dead link");
	xmit_gate_a: assert property (handoff_go && handoff == 3'h1
		|-> $past(dma_xfer_zero[xmit_dev])) else $error("sent while counting");
	req_hold_a: assert property (mem_rd_req && !mem_rd_ack && !dev_error && !cw |=> mem_rd_req)
		else $error("fetch dropped");
	hdr_keep_a: assert property (mem_rd_ack |=> cmd_header == $past(mem_rd_data))
		else $error("header lost");
	code_ok_a: assert property (handoff_go |-> handoff != 3'h0 && handoff != 3'h7)
		else $error("bad handoff code");
endmodule : fis_sched_monitor
bind fis_switch_port_scheduler fis_sched_monitor u_fis_sched_monitor (.*);

//--- test/hdr_mem_model.sv
// Purpose: header memory behind the fetch port
// Assumes: one read outstanding
// Notes:   slow adds a wait before each answer
`timescale 1ns/10ps
module hdr_mem_model (
	input wire logic        core_clk,
	input wire logic        slow,
	input wire logic        mem_rd_req,
	input wire logic [63:0] mem_rd_addr,
	output logic            mem_rd_ack = 1'b0,
	output logic [31:0]     mem_rd_data = 32'h0
);
	logic [2:0] wait_q = 3'h0;
	// answer after the wait, scramble the data otherwise
	always @(posedge core_clk) begin
		mem_rd_ack <= 1'b0;
		mem_rd_data <= ~mem_rd_data;
		wait_q <= (mem_rd_req && !mem_rd_ack) ? wait_q + 3'h1 : 3'h0;
		if (mem_rd_req && !mem_rd_ack && wait_q >= {slow, 2'h0}) begin
			mem_rd_ack <= 1'b1;
			mem_rd_data <= {mem_rd_addr[23:0], 8'h05};
		end
	end
endmodule : hdr_mem_model

//--- test/fis_switch_port_scheduler_bench.sv
// Purpose: directed run of the port scheduler
// Assumes: header memory model on the fetch port
// Notes:   event bits walk the idle priorities
`timescale 1ns/10ps
module fis_switch_port_scheduler_bench;
	import fis_sched_pkg::*;
	logic        core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b1, s;
	logic        handler_done = 1'b0, cmd_sent = 1'b0, cmd_done = 1'b0, dev_status_upd = 1'b0;
	logic        dev_error = 1'b0, dev_status_bsy = 1'b0, dev_status_drq = 1'b0, handoff_go;
	logic        data_fis_rx, nondata_fis_rx, link_low_power, idle_timeout_flag, phy_listen;
	logic        sleep_exit_only_cap, mem_rd_req, mem_rd_ack, dev_power_en;
	logic [2:0]  handoff;
	logic [3:0]  link_detect_status = LINK_UP, dev_status_dev = 4'h0, dev_error_dev = 4'h0, xmit_dev;
	logic [4:0]  cmd_done_slot = 5'h0, ev = 5'h0, xmit_slot;
	logic [7:0]  reg_addr = 8'h0;
	logic [15:0] dma_xfer_zero = 16'hfdff;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_rd_data, cmd_header;
	logic [63:0] mem_rd_addr;
	int          error_cnt = 0, total_checks = 0;
	// frame and power events as one vector
	assign {data_fis_rx, nondata_fis_rx, link_low_power} = ev[4:2];
	assign {idle_timeout_flag, sleep_exit_only_cap} = ev[1:0];
	fis_switch_port_scheduler u_fis_switch_port_scheduler (.*);
	hdr_mem_model u_hdr_mem_model (.*);
	always #5 core_clk = ~core_clk;
	task automatic chk(input logic [63:0] g, e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask : rd
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	// wait for a hand-off, check its code, then finish it
	task automatic hgo(input logic [2:0] e);
		int i;
		for (i = 0; i < 60 && handoff_go !== 1'b1; i++) @(posedge core_clk) #1;
		if (i == 60) begin
			error_cnt++;
			close_out();
		end
		chk(handoff, e);
		@(posedge core_clk) ev <= 5'h0;
		{handler_done, cmd_sent} <= 2'b11;
		@(posedge core_clk) {handler_done, cmd_sent} <= 2'b00;
	endtask : hgo
	initial begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		wr(OFS_CTRL, 32'h3);
		wr(OFS_CLB_LO, 32'h1000);
		wr(OFS_SLOT_DEV, 32'h0f01);
		wr(OFS_SLOT_DEV, 32'h0200);
		wr(OFS_SLOT_DEV, 32'h0902);
		wr(OFS_CTRL, 32'h9);
		rd(OFS_STATUS, 32'h1, 32'h1);
		chk(dev_power_en, 1);
		rd(8'h40, 32'hffff_ffff, 32'h0);
		$display("test 1 done");
		wr(OFS_ISSUE, 32'h7);
		hgo(3'h1);
		#1 chk({xmit_dev, xmit_slot, cmd_header}, {4'hf, 5'h1, 32'h0010_2005});
		slow <= 1'b0;
		hgo(3'h1);
		#1 chk({xmit_dev, xmit_slot}, {4'h2, 5'h0});
		@(posedge core_clk) dev_status_dev <= 4'h2;
		{cmd_done, dev_status_upd} <= 2'b11;
		@(posedge core_clk) {cmd_done, dev_status_upd} <= 2'b00;
		rd(OFS_ISSUE, 32'h3, 32'h2);
		$display("test 2 done");
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk) ev <= {4'hf >> k, 1'b0};
			hgo(k == 3 ? 3'h6 : 3'(k + 2));
		end
		wr(OFS_CTRL, 32'h1000_0009);
		hgo(3'h5);
		$display("test 3 done");
		@(posedge core_clk) dev_error_dev <= 4'h9;
		dev_error <= 1'b1;
		@(posedge core_clk) dev_error <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(OFS_FBS, 32'hf02, 32'h902);
		wr(OFS_FBS, 32'h1);
		repeat (2) @(posedge core_clk);
		rd(OFS_FBS, 32'h3, 32'h0);
		rd(OFS_ISSUE, 32'h4, 32'h0);
		$display("test 4 done");
		@(posedge core_clk) link_detect_status <= 4'h0;
		rd(OFS_STATUS, 32'hf0, 32'h0);
		@(posedge core_clk) link_detect_status <= LINK_UP;
		wr(OFS_CTRL, 32'h0);
		s = 1'b0;
		repeat (3) @(posedge core_clk) #1 s |= phy_listen;
		chk({s, dev_power_en}, 2'b11);
		wr(OFS_CTRL, 32'h4);
		repeat (3) @(posedge core_clk);
		#1 chk(dev_power_en, 0);
		$display("test 5 done");
		close_out();
	end
endmodule : fis_switch_port_scheduler_bench
